// ### src/lpmc_ctrl.v
// Overview of operation
// - one active mode plus seven software-selected low-power modes.
// - interrupt wakes sleep levels zero and one, or two to four with an enabled wake source, so CPU can service it.
// - return from interrupt resumes the low-power mode held before wake.
// - rtc-only and full shutdown switch core supply off; no retention.
// - sleep level four keeps low-frequency clocks when a peripheral requests them.
// - vector accelerator runs only in active or sleep level zero.
// - accelerator uses shared 4KB of 8KB ram, also usable by application.
// - cpu and accelerator run independently; shared ram accesses are arbitrated.
// - unsupported request enters the nearest mode supporting peripheral clock state.
// - peripheral clock above 50 kHz is high-frequency, else low-frequency.
`include "lpmc_consts.vh"
module lpmc_ctrl
#(
    parameter RAM_AW = 13
)
(
    // clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // cpu mode request and interrupt return
    input wire mode_req_i,
    input wire [2:0] mode_sel_i,
    input wire irq_i,
    input wire reti_i,
    // wake sources from pins, async
    input wire [3:0] wake_src_i,
    // peripheral clock demand
    input wire [31:0] periph_freq_hz_i,
    input wire periph_clk_active_i,
    input wire periph_unclocked_i,
    input wire lf_clk_req_i,
    // accelerator
    input wire accel_start_i,
    input wire accel_done_i,
    input wire accel_ram_req_i,
    input wire [RAM_AW-1:0] accel_ram_addr_i,
    // cpu ram access
    input wire cpu_ram_req_i,
    input wire [RAM_AW-1:0] cpu_ram_addr_i,
    // status and gates
    output reg [2:0] mode_o,
    output reg main_clk_en_o,
    output reg sub_main_clk_en_o,
    output reg aux_clk_en_o,
    output reg lf_crystal_en_o,
    output reg vlo_osc_en_o,
    output reg core_supply_en_o,
    output reg cpu_run_o,
    output reg accel_active_o,
    output wire accel_ram_gnt_o,
    output wire cpu_ram_gnt_o,
    output wire accel_addr_err_o,
    output reg wake_o
);
    localparam ST_RUN = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_ISR = 2'h2;
    localparam ST_SD = 2'h3;
    localparam integer SHARED_BASE_INT = `LPMC_RAM_BYTES - `LPMC_SHARED_BYTES;
    localparam [RAM_AW-1:0] SHARED_BASE = SHARED_BASE_INT[RAM_AW-1:0];

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [2:0] mode_nxt;
    reg [2:0] saved_r;
    reg [2:0] saved_nxt;
    reg [3:0] wk_s1_r;
    reg [3:0] wk_s2_r;
    reg accel_nxt;
    reg wake_nxt;
    reg arb_last_r;
    wire [2:0] grant_mode;

    lpmc_mode_limit u_limit
    (
        .req_mode_i(mode_sel_i),
        .periph_freq_hz_i(periph_freq_hz_i),
        .periph_clk_active_i(periph_clk_active_i),
        .periph_unclocked_i(periph_unclocked_i),
        .grant_mode_o(grant_mode)
    );

    // per-mode wake source mask
    function [3:0] wake_mask;
        input [2:0] m;
        begin
            case (m)
                `LPMC_MODE_SL0, `LPMC_MODE_SL1: wake_mask = 4'hf;
                `LPMC_MODE_SL2, `LPMC_MODE_SL3: wake_mask = 4'hf;
                `LPMC_MODE_SL4: wake_mask = (4'h1 << `LPMC_WAKE_PIN) |
                    (4'h1 << `LPMC_WAKE_COMP);
                `LPMC_MODE_RTC_SD: wake_mask = (4'h1 << `LPMC_WAKE_RTC) |
                    (4'h1 << `LPMC_WAKE_PIN);
                `LPMC_MODE_FULL_SD: wake_mask = 4'h1 << `LPMC_WAKE_PIN;
                default: wake_mask = 4'h0;
            endcase
        end
    endfunction

    // pins are asynchronous to clk_sys_i
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            wk_s1_r <= 4'h0;
            wk_s2_r <= 4'h0;
        end
        else
        begin
            wk_s1_r <= wake_src_i;
            wk_s2_r <= wk_s1_r;
        end
    end

    wire src_wake = |(wk_s2_r & wake_mask(mode_o));
    // levels 0/1 take any interrupt; deeper levels need an enabled source
    wire irq_wake = irq_i && (mode_o <= `LPMC_MODE_SL1 || src_wake);

    always @*
    begin
        st_nxt = st_r;
        mode_nxt = mode_o;
        saved_nxt = saved_r;
        accel_nxt = accel_active_o;
        wake_nxt = 1'b0;
        case (st_r)
            ST_RUN:
            begin
                if (accel_start_i)
                    accel_nxt = 1'b1;
                if (mode_req_i && mode_sel_i != `LPMC_MODE_ACTIVE)
                begin
                    mode_nxt = grant_mode;
                    saved_nxt = grant_mode;
                    if (grant_mode >= `LPMC_MODE_RTC_SD)
                    begin
                        st_nxt = ST_SD;
                        accel_nxt = 1'b0;
                    end
                    else
                    begin
                        st_nxt = ST_SLEEP;
                        if (grant_mode != `LPMC_MODE_SL0)
                            accel_nxt = 1'b0;
                    end
                end
            end
            ST_SLEEP:
            begin
                if (irq_wake)
                begin
                    st_nxt = ST_ISR;
                    mode_nxt = `LPMC_MODE_ACTIVE;
                    wake_nxt = 1'b1;
                end
            end
            ST_ISR:
            begin
                if (accel_start_i)
                    accel_nxt = 1'b1;
                if (reti_i)
                begin
                    st_nxt = ST_SLEEP;
                    mode_nxt = saved_r;
                    if (saved_r != `LPMC_MODE_SL0)
                        accel_nxt = 1'b0;
                end
                else if (mode_req_i && mode_sel_i == `LPMC_MODE_ACTIVE)
                    st_nxt = ST_RUN;
            end
            ST_SD:
            begin
                // no retention: waking restarts from active as if reset
                if (src_wake)
                begin
                    st_nxt = ST_RUN;
                    mode_nxt = `LPMC_MODE_ACTIVE;
                    wake_nxt = 1'b1;
                end
            end
            default:
                st_nxt = ST_RUN;
        endcase
        if (accel_done_i && accel_active_o)
            accel_nxt = 1'b0;
    end

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_r <= ST_RUN;
            mode_o <= `LPMC_MODE_ACTIVE;
            saved_r <= `LPMC_MODE_ACTIVE;
            accel_active_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            mode_o <= mode_nxt;
            saved_r <= saved_nxt;
            accel_active_o <= accel_nxt;
            wake_o <= wake_nxt;
        end
    end

    // gates follow the registered mode
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            main_clk_en_o <= 1'b1;
            sub_main_clk_en_o <= 1'b1;
            aux_clk_en_o <= 1'b1;
            lf_crystal_en_o <= 1'b1;
            vlo_osc_en_o <= 1'b1;
            core_supply_en_o <= 1'b1;
            cpu_run_o <= 1'b1;
        end
        else
        begin
            main_clk_en_o <= (mode_nxt == `LPMC_MODE_ACTIVE) || accel_nxt;
            sub_main_clk_en_o <= (mode_nxt < `LPMC_MODE_SL2);
            aux_clk_en_o <= (mode_nxt < `LPMC_MODE_SL4);
            lf_crystal_en_o <= (mode_nxt < `LPMC_MODE_SL4) ||
                (mode_nxt == `LPMC_MODE_RTC_SD) ||
                (mode_nxt == `LPMC_MODE_SL4 && lf_clk_req_i);
            vlo_osc_en_o <= (mode_nxt < `LPMC_MODE_SL4) ||
                (mode_nxt == `LPMC_MODE_SL4 && lf_clk_req_i);
            core_supply_en_o <= (mode_nxt < `LPMC_MODE_RTC_SD);
            cpu_run_o <= (mode_nxt == `LPMC_MODE_ACTIVE);
        end
    end

    // shared window is the upper half of system ram
    wire accel_in_win = accel_ram_addr_i >= SHARED_BASE;
    wire cpu_in_win = cpu_ram_addr_i >= SHARED_BASE;
    wire accel_rq = accel_ram_req_i && accel_active_o && accel_in_win;
    wire clash = accel_rq && cpu_ram_req_i && cpu_in_win;
    assign accel_addr_err_o = accel_ram_req_i && accel_active_o && !accel_in_win;
    // round robin on clash so neither side starves
    assign accel_ram_gnt_o = accel_rq && (!clash || !arb_last_r);
    assign cpu_ram_gnt_o = cpu_ram_req_i && (!clash || arb_last_r);

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            arb_last_r <= 1'b0;
        else if (clash)
            arb_last_r <= !arb_last_r;
    end
endmodule

// ### shared/lpmc_consts.vh
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH
// mode encodings
`define LPMC_MODE_W 3
`define LPMC_MODE_ACTIVE 3'h0
`define LPMC_MODE_SL0 3'h1
`define LPMC_MODE_SL1 3'h2
`define LPMC_MODE_SL2 3'h3
`define LPMC_MODE_SL3 3'h4
`define LPMC_MODE_SL4 3'h5
`define LPMC_MODE_RTC_SD 3'h6
`define LPMC_MODE_FULL_SD 3'h7
// wake source vector bit positions
`define LPMC_WAKE_W 4
`define LPMC_WAKE_LF 0
`define LPMC_WAKE_RTC 1
`define LPMC_WAKE_PIN 2
`define LPMC_WAKE_COMP 3
// peripheral clock frequency threshold in hz
`define LPMC_LF_LIMIT_HZ 50000
// shared ram geometry in bytes
`define LPMC_RAM_BYTES 8192
`define LPMC_SHARED_BYTES 4096
`endif

// ### src/lpmc_mode_limit.v
`include "lpmc_consts.vh"
// clamps a requested mode to the deepest one the peripherals can tolerate
module lpmc_mode_limit
(
    // request
    input wire [2:0] req_mode_i,
    // peripheral demands
    input wire [31:0] periph_freq_hz_i,
    input wire periph_clk_active_i,
    input wire periph_unclocked_i,
    // result
    output reg [2:0] grant_mode_o
);
    reg hf_need;
    reg lf_need;
    always @*
    begin
        hf_need = periph_clk_active_i && (periph_freq_hz_i > `LPMC_LF_LIMIT_HZ);
        lf_need = periph_clk_active_i && !hf_need;
        grant_mode_o = req_mode_i;
        // shutdown modes reset peripherals; active state keeps us retained
        if (hf_need && req_mode_i > `LPMC_MODE_SL1)
            grant_mode_o = `LPMC_MODE_SL1;
        else if (lf_need && req_mode_i > `LPMC_MODE_SL3)
            grant_mode_o = `LPMC_MODE_SL3;
        else if (periph_unclocked_i && req_mode_i > `LPMC_MODE_SL4)
            grant_mode_o = `LPMC_MODE_SL4;
    end
endmodule

// ### dv/lpmc_ctrl_checker.sv
`include "lpmc_consts.vh"
module lpmc_ctrl_checker
#(
    parameter RAM_AW = 13
)
(
    // watched inputs
    input wire clk_sys_i,
    input wire rst_i,
    input wire mode_req_i,
    input wire [2:0] mode_sel_i,
    input wire [31:0] periph_freq_hz_i,
    input wire periph_clk_active_i,
    input wire lf_clk_req_i,
    input wire accel_ram_req_i,
    input wire [RAM_AW-1:0] accel_ram_addr_i,
    // watched outputs
    input wire [2:0] mode_o,
    input wire main_clk_en_o,
    input wire sub_main_clk_en_o,
    input wire aux_clk_en_o,
    input wire lf_crystal_en_o,
    input wire vlo_osc_en_o,
    input wire core_supply_en_o,
    input wire accel_active_o,
    input wire accel_ram_gnt_o,
    input wire accel_addr_err_o,
    input wire wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // isr also shows mode 0; the bench never requests a deep mode there
    sequence s_hf_req;
        mode_req_i && mode_o == `LPMC_MODE_ACTIVE && periph_clk_active_i
            && periph_freq_hz_i > 32'd50000 && mode_sel_i > `LPMC_MODE_SL1;
    endsequence
    sequence s_sl4_lf;
        mode_o == `LPMC_MODE_SL4 && lf_clk_req_i ##1 mode_o == `LPMC_MODE_SL4;
    endsequence
    property p_clamp; s_hf_req |=> mode_o == `LPMC_MODE_SL1; endproperty
    property p_lf_keep; s_sl4_lf |-> lf_crystal_en_o && vlo_osc_en_o; endproperty
    property p_supply; mode_o >= `LPMC_MODE_RTC_SD |-> !core_supply_en_o; endproperty
    property p_accel; accel_active_o |-> mode_o <= `LPMC_MODE_SL0; endproperty
    property p_main; mode_o != `LPMC_MODE_ACTIVE && !accel_active_o |-> !main_clk_en_o;
    endproperty
    property p_sub; mode_o >= `LPMC_MODE_SL2 |-> !sub_main_clk_en_o; endproperty
    property p_aux; mode_o >= `LPMC_MODE_SL4 |-> !aux_clk_en_o; endproperty
    property p_wake; wake_o |-> mode_o == `LPMC_MODE_ACTIVE ##1 !wake_o; endproperty
    property p_err;
        accel_ram_req_i && accel_active_o
            && accel_ram_addr_i < (`LPMC_RAM_BYTES - `LPMC_SHARED_BYTES)
            |-> accel_addr_err_o && !accel_ram_gnt_o;
    endproperty
    property p_gnt; accel_ram_gnt_o |-> accel_ram_req_i && !accel_addr_err_o; endproperty
    a_clamp: assert property (p_clamp) else $error("deep request not clamped");
    a_lf_keep: assert property (p_lf_keep) else $error("lf clocks dropped");
    a_supply: assert property (p_supply) else $error("core supply on");
    a_accel: assert property (p_accel) else $error("accel in deep mode");
    a_main: assert property (p_main) else $error("main clock not gated");
    a_sub: assert property (p_sub) else $error("sub-main clock not gated");
    a_aux: assert property (p_aux) else $error("aux clock not gated");
    a_wake: assert property (p_wake) else $error("bad wake pulse");
    a_err: assert property (p_err) else $error("accel outside window");
    a_gnt: assert property (p_gnt) else $error("grant without request");
endmodule

bind lpmc_ctrl lpmc_ctrl_checker #(.RAM_AW(RAM_AW)) i_lpmc_ctrl_checker (.clk_sys_i, .rst_i,
    .mode_req_i, .mode_sel_i, .periph_freq_hz_i, .periph_clk_active_i, .lf_clk_req_i,
    .accel_ram_req_i, .accel_ram_addr_i, .mode_o, .main_clk_en_o, .sub_main_clk_en_o,
    .aux_clk_en_o, .lf_crystal_en_o, .vlo_osc_en_o, .core_supply_en_o, .accel_active_o,
    .accel_ram_gnt_o, .accel_addr_err_o, .wake_o);

// ### dv/lpmc_cpu_model.sv
module lpmc_cpu_model
(
    // clock
    input wire clk_sys_i,
    // mode requests and interrupts
    output logic mode_req_o = 1'b0,
    output logic [2:0] mode_sel_o = 3'h0,
    output logic irq_o = 1'b0,
    output logic reti_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task req(input logic [2:0] m);
        @(posedge clk_sys_i);
        #1;
        mode_req_o = 1'b1;
        mode_sel_o = m;
        @(posedge clk_sys_i);
        #1;
        mode_req_o = 1'b0;
        mode_sel_o = ~m; // released select is inverted, away from the requested mode
    endtask
    task ret;
        @(posedge clk_sys_i);
        #1;
        reti_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reti_o = 1'b0;
    endtask
    task set_irq(input logic v);
        irq_o = v;
    endtask
endmodule

// ### dv/tb_low_power_mode_controller.sv
`include "lpmc_consts.vh"
module tb_low_power_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    wire mreq, irq, reti;
    wire [2:0] msel;
    logic [3:0] wsrc = 4'h0;
    logic [31:0] freq = 32'h0;
    logic cact = 0, lfreq = 0, ast = 0, areq = 0, creq = 0, punc = 0, adone = 0;
    logic [12:0] aad = 13'h0, cad = 13'h0;
    logic [2:0] mode;
    logic men, sen, xen, lfx, vlo, sup, run, act, agnt, cgnt, aerr, wake;
    int err_count = 0;
    int compares = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    lpmc_cpu_model i_lpmc_cpu_model (.clk_sys_i(clk_sys_i), .mode_req_o(mreq),
        .mode_sel_o(msel), .irq_o(irq), .reti_o(reti));
    lpmc_ctrl i_lpmc_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_req_i(mreq),
        .mode_sel_i(msel), .irq_i(irq), .reti_i(reti), .wake_src_i(wsrc),
        .periph_freq_hz_i(freq), .periph_clk_active_i(cact), .periph_unclocked_i(punc),
        .lf_clk_req_i(lfreq), .accel_start_i(ast), .accel_done_i(adone),
        .accel_ram_req_i(areq), .accel_ram_addr_i(aad), .cpu_ram_req_i(creq),
        .cpu_ram_addr_i(cad), .mode_o(mode), .main_clk_en_o(men), .sub_main_clk_en_o(sen),
        .aux_clk_en_o(xen), .lf_crystal_en_o(lfx), .vlo_osc_en_o(vlo),
        .core_supply_en_o(sup), .cpu_run_o(run), .accel_active_o(act),
        .accel_ram_gnt_o(agnt), .cpu_ram_gnt_o(cgnt), .accel_addr_err_o(aerr), .wake_o(wake));
    task tk(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task conclude;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task wt;
        int i;
        for (i = 0; i < 8 && wake !== 1'b1; i++)
            tk(1);
        if (wake !== 1'b1)
        begin
            err_count++;
            $display("mismatch wake expected 1 seen %b", wake);
            conclude;
        end
    endtask
    task rs;
        rst_i = 1;
        i_lpmc_cpu_model.set_irq(1'b0);
        tk(2);
        rst_i = 0;
        {wsrc, cact, lfreq, punc} = 7'h0;
    endtask
    task s_sl2;
        i_lpmc_cpu_model.req(`LPMC_MODE_SL2);
        chk("mode", `LPMC_MODE_SL2, mode);
        chk("main", 0, men);
        chk("sub", 0, sen);
        chk("aux", 1, xen);
        chk("run", 0, run);
        wsrc = 4'h1;
        tk(3);
        i_lpmc_cpu_model.set_irq(1'b1);
        wt;
        chk("mode", `LPMC_MODE_ACTIVE, mode);
        i_lpmc_cpu_model.set_irq(1'b0);
        wsrc = 4'h0;
        i_lpmc_cpu_model.ret;
        chk("mode", `LPMC_MODE_SL2, mode);
    endtask
    task s_sl4;
        rs;
        lfreq = 1;
        i_lpmc_cpu_model.req(`LPMC_MODE_SL4);
        chk("lfx", 1, lfx);
        chk("vlo", 1, vlo);
        chk("aux", 0, xen);
        wsrc = 4'h1;
        i_lpmc_cpu_model.set_irq(1'b1);
        tk(5);
        chk("mode", `LPMC_MODE_SL4, mode);
        wsrc = 4'h4;
        wt;
        chk("mode", `LPMC_MODE_ACTIVE, mode);
        // leave the service routine, then a shallow request must be taken
        i_lpmc_cpu_model.req(`LPMC_MODE_ACTIVE);
        i_lpmc_cpu_model.req(`LPMC_MODE_SL1);
        chk("mode", `LPMC_MODE_SL1, mode);
        chk("sub", 1, sen);
        chk("main", 0, men);
    endtask
    task s_shut;
        int k;
        for (k = 6; k < 8; k++)
        begin
            rs;
            i_lpmc_cpu_model.req(k[2:0]);
            chk("supply", 0, sup);
            wsrc = 4'h4;
            wt;
            chk("mode", `LPMC_MODE_ACTIVE, mode);
        end
    endtask
    task s_clamp;
        rs;
        cact = 1;
        freq = 32'd50001;
        i_lpmc_cpu_model.req(`LPMC_MODE_SL4);
        chk("mode", `LPMC_MODE_SL1, mode);
        rs;
        cact = 1;
        freq = 32'd50000;
        i_lpmc_cpu_model.req(`LPMC_MODE_SL4);
        chk("mode", `LPMC_MODE_SL3, mode);
        rs;
        punc = 1;
        i_lpmc_cpu_model.req(`LPMC_MODE_FULL_SD);
        chk("mode", `LPMC_MODE_SL4, mode);
        chk("supply", 1, sup);
    endtask
    task s_accel;
        rs;
        ast = 1;
        tk(1);
        ast = 0;
        chk("act", 1, act);
        {areq, aad} = {1'b1, 13'h64};
        tk(1);
        chk("aerr", 1, aerr);
        chk("agnt", 0, agnt);
        // clash held over edges: each clashing edge hands the turn over
        {aad, creq, cad} = {13'h1000, 1'b1, 13'h1000};
        tk(1);
        chk("cgnt", 1, cgnt);
        chk("agnt", 0, agnt);
        tk(1);
        chk("agnt", 1, agnt);
        chk("cgnt", 0, cgnt);
        areq = 0;
        tk(1);
        chk("cgnt", 1, cgnt);
        creq = 0;
        i_lpmc_cpu_model.req(`LPMC_MODE_SL0);
        chk("main", 1, men);
        adone = 1;
        tk(1);
        adone = 0;
        chk("act", 0, act);
        chk("main", 0, men);
    endtask
    initial
    begin
        tk(12);
        rst_i = 0;
        chk("mode", `LPMC_MODE_ACTIVE, mode);
        s_sl2;
        s_sl4;
        s_shut;
        s_clamp;
        s_accel;
        conclude;
    end
endmodule
